// >>> core/mcc_defs.vh
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH

// Machine cycle counter
`define MCC_CNT_W 3
`define MCC_CNT_ZERO 3'h0
`define MCC_CNT_LAST 3'h7
`define MCC_TPA_CNT 3'h0
`define MCC_TPB_CNT 3'h5
`define MCC_WR_ON 3'h4
`define MCC_WR_OFF 3'h5

// Synchroniser vector: clear, wait, dma in, dma out, interrupt, bus[7:0]
`define MCC_SYNC_W 13
`define MCC_SYNC_RST 13'h0800
`define MCC_SB_CLEAR 12
`define MCC_SB_WAIT 11
`define MCC_SB_DMAI 10
`define MCC_SB_DMAO 9
`define MCC_SB_INT 8

// Reset and start values
`define MCC_START_ADDR 16'h0000
`define MCC_ADDR_ONE 16'h0001
`define MCC_NIB_ZERO 4'h0
`define MCC_BYTE_ZERO 8'h00
`define MCC_IE_RST 1'b1

// Opcodes and fields
`define MCC_OP_RET 8'h70
`define MCC_OP_DIS 8'h71
`define MCC_OP_QOFF 8'h7a
`define MCC_OP_QON 8'h7b
`define MCC_I_SEP 4'hd
`define MCC_I_SEX 4'he
`define MCC_I_LONG 4'hc

// Interrupt entry selectors
`define MCC_INT_X 4'h2
`define MCC_INT_P 4'h1

// State code output
`define MCC_SC_FETCH 2'h0
`define MCC_SC_EXEC 2'h1
`define MCC_SC_DMA 2'h2
`define MCC_SC_INT 2'h3

`endif

// >>> core/mcc_core.v
// Function
// - Read strobe low throughout every read cycle.
// - Write strobe pulses low with valid address.
// - Eight clocks per cycle; two or three cycles.
// - Clear and wait high selects run mode.
// - Reset zeroes I,N,X,P,Q,bus; sets IE.
// - Reset suppresses timing pulses, holds reset state.
// - Init cycle on reset exit clears X,P,R0.
// - Load mode idles, DMA fills memory from 0000.
// - Wait low with clear high halts and holds all outputs once reset exit and the init cycle are done.
// - Wait high resumes after the two-flop synchroniser delay.
// - No DMA or interrupt acknowledge while paused.
// - Run starts one cycle later at 0000.
// - Pending DMA at run start enters DMA first.
// - Interrupts ignored until first instruction or DMA.
// - Opcode 71 with byte 00 clears IE.
// - Run entered from reset or pause.
// - Static logic keeps state while clock stops.
`timescale 1ns/1ps
`include "mcc_defs.vh"

module mcc_core (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire clear_n,
    input wire wait_n,
    input wire dma_in_req,
    input wire dma_out_req,
    input wire int_req,
    input wire [7:0] data_bus_in,
    output reg [7:0] data_bus_out,
    output reg data_bus_oe,
    output reg [15:0] mem_addr,
    output reg mem_read_strobe_n,
    output reg mem_write_strobe_n,
    output reg timing_pulse_first,
    output reg timing_pulse_second,
    output reg [1:0] state_code,
    output reg [3:0] opcode_hi,
    output reg [3:0] opcode_lo,
    output reg [3:0] data_ptr_sel,
    output reg [3:0] pc_sel,
    output reg q_out,
    output reg interrupt_enable_flag
);

    localparam [2:0] ST_RESET = 3'h0;
    localparam [2:0] ST_INIT = 3'h1;
    localparam [2:0] ST_LOAD = 3'h2;
    localparam [2:0] ST_FETCH = 3'h3;
    localparam [2:0] ST_EXEC = 3'h4;
    localparam [2:0] ST_EXEC2 = 3'h5;
    localparam [2:0] ST_DMA = 3'h6;
    localparam [2:0] ST_INT = 3'h7;
    localparam [`MCC_SYNC_W-1:0] SYNC_RST = `MCC_SYNC_RST;

    reg [`MCC_SYNC_W-1:0] sync1_q;
    reg [`MCC_SYNC_W-1:0] sync2_q;
    reg [2:0] st_q;
    reg [`MCC_CNT_W-1:0] cnt_q;
    reg started_q;
    reg dma_dir_in_q;
    reg [15:0] regs_q [0:15];
    reg [2:0] st_next;
    reg dir_next;
    integer i;

    wire [`MCC_SYNC_W-1:0] sync_in;
    wire clear_s;
    wire wait_s;
    wire dmai_s;
    wire dmao_s;
    wire int_s;
    wire [7:0] bus_s;
    wire mode_reset;
    wire mode_load;
    wire mode_pause;
    wire cyc_end;
    wire tpb_now;
    wire [7:0] op_now;

    assign sync_in = {clear_n, wait_n, dma_in_req, dma_out_req, int_req, data_bus_in};

    // Two-flop synchronisers for every pin input except rst_n and clk_en
    genvar g;
    generate
        for (g = 0; g < `MCC_SYNC_W; g = g + 1) begin : g_sync
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[g] <= SYNC_RST[g];
                    sync2_q[g] <= SYNC_RST[g];
                end else if (clk_en) begin
                    sync1_q[g] <= sync_in[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    assign clear_s = sync2_q[`MCC_SB_CLEAR];
    assign wait_s = sync2_q[`MCC_SB_WAIT];
    assign dmai_s = sync2_q[`MCC_SB_DMAI];
    assign dmao_s = sync2_q[`MCC_SB_DMAO];
    assign int_s = sync2_q[`MCC_SB_INT];
    assign bus_s = sync2_q[7:0];

    assign mode_reset = !clear_s && wait_s;
    assign mode_load = !clear_s && !wait_s;
    assign mode_pause = clear_s && !wait_s;
    assign cyc_end = (cnt_q == `MCC_CNT_LAST);
    assign tpb_now = (cnt_q == `MCC_TPB_CNT);
    assign op_now = {opcode_hi, opcode_lo};

    // Cycles that read memory onto the bus
    function is_read;
        input [2:0] st;
        input [7:0] op;
        input dir_in;
        begin
            case (st)
                ST_FETCH: begin
                    is_read = 1'b1;
                end
                ST_EXEC: begin
                    is_read = (op == `MCC_OP_RET) || (op == `MCC_OP_DIS);
                end
                ST_DMA: begin
                    is_read = !dir_in;
                end
                default: begin
                    is_read = 1'b0;
                end
            endcase
        end
    endfunction

    // Choice at the end of a machine cycle
    always @* begin
        st_next = ST_FETCH;
        dir_next = dmai_s;
        if (dmai_s || dmao_s) begin
            st_next = ST_DMA;
        end else if (mode_load) begin
            st_next = ST_LOAD;
        end else if (int_s && interrupt_enable_flag && started_q) begin
            st_next = ST_INT;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RESET;
            cnt_q <= `MCC_CNT_ZERO;
            started_q <= 1'b0;
            dma_dir_in_q <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                regs_q[i] <= `MCC_START_ADDR;
            end
            data_bus_out <= `MCC_BYTE_ZERO;
            data_bus_oe <= 1'b1;
            mem_addr <= `MCC_START_ADDR;
            mem_read_strobe_n <= 1'b1;
            mem_write_strobe_n <= 1'b1;
            timing_pulse_first <= 1'b0;
            timing_pulse_second <= 1'b0;
            state_code <= `MCC_SC_FETCH;
            opcode_hi <= `MCC_NIB_ZERO;
            opcode_lo <= `MCC_NIB_ZERO;
            data_ptr_sel <= `MCC_NIB_ZERO;
            pc_sel <= `MCC_NIB_ZERO;
            q_out <= 1'b0;
            interrupt_enable_flag <= `MCC_IE_RST;
        end else if (clk_en) begin
            if (mode_reset) begin
                st_q <= ST_RESET;
                cnt_q <= `MCC_CNT_ZERO;
                started_q <= 1'b0;
                opcode_hi <= `MCC_NIB_ZERO;
                opcode_lo <= `MCC_NIB_ZERO;
                data_ptr_sel <= `MCC_NIB_ZERO;
                pc_sel <= `MCC_NIB_ZERO;
                q_out <= 1'b0;
                interrupt_enable_flag <= `MCC_IE_RST;
                data_bus_out <= `MCC_BYTE_ZERO;
                data_bus_oe <= 1'b1;
                mem_read_strobe_n <= 1'b1;
                mem_write_strobe_n <= 1'b1;
                timing_pulse_first <= 1'b0;
                timing_pulse_second <= 1'b0;
            end else if (st_q == ST_RESET) begin
                st_q <= ST_INIT;
                cnt_q <= `MCC_CNT_ZERO;
                data_bus_oe <= 1'b0;
            end else if (mode_pause && st_q != ST_INIT) begin
                // Everything held; no DMA or interrupt is taken here
                st_q <= st_q;
            end else begin
                // Running
                cnt_q <= cnt_q + 1'b1;
                data_bus_oe <= 1'b0;
                timing_pulse_first <= (cnt_q == `MCC_TPA_CNT);
                timing_pulse_second <= tpb_now;
                mem_read_strobe_n <= !is_read(st_q, op_now, dma_dir_in_q);
                mem_write_strobe_n <= !(st_q == ST_DMA && dma_dir_in_q
                    && cnt_q >= `MCC_WR_ON && cnt_q <= `MCC_WR_OFF);
                // Address latched once per machine cycle so it stands all cycle
                if (cnt_q == `MCC_CNT_ZERO) begin
                case (st_q)
                    ST_FETCH: begin
                        mem_addr <= regs_q[pc_sel];
                        state_code <= `MCC_SC_FETCH;
                    end
                    ST_EXEC: begin
                        mem_addr <= regs_q[data_ptr_sel];
                        state_code <= `MCC_SC_EXEC;
                    end
                    ST_EXEC2: begin
                        mem_addr <= regs_q[pc_sel];
                        state_code <= `MCC_SC_EXEC;
                    end
                    ST_DMA: begin
                        mem_addr <= regs_q[0];
                        state_code <= `MCC_SC_DMA;
                    end
                    ST_INT: begin
                        mem_addr <= regs_q[pc_sel];
                        state_code <= `MCC_SC_INT;
                    end
                    default: begin
                        mem_addr <= regs_q[pc_sel];
                    end
                endcase
                end
                case (st_q)
                    ST_INIT: begin
                        if (cyc_end) begin
                            data_ptr_sel <= `MCC_NIB_ZERO;
                            pc_sel <= `MCC_NIB_ZERO;
                            regs_q[0] <= `MCC_START_ADDR;
                            st_q <= st_next;
                            dma_dir_in_q <= dir_next;
                        end
                    end
                    ST_LOAD: begin
                        // Idle cycles until an I/O device asks for DMA
                        if (cyc_end) begin
                            st_q <= st_next;
                            dma_dir_in_q <= dir_next;
                        end
                    end
                    ST_FETCH: begin
                        if (tpb_now) begin
                            opcode_hi <= bus_s[7:4];
                            opcode_lo <= bus_s[3:0];
                            regs_q[pc_sel] <= regs_q[pc_sel] + `MCC_ADDR_ONE;
                        end
                        if (cyc_end) begin
                            st_q <= ST_EXEC;
                        end
                    end
                    ST_EXEC: begin
                        if (tpb_now) begin
                            if (op_now == `MCC_OP_RET || op_now == `MCC_OP_DIS) begin
                                data_ptr_sel <= bus_s[7:4];
                                pc_sel <= bus_s[3:0];
                                interrupt_enable_flag <= (op_now == `MCC_OP_RET);
                                regs_q[data_ptr_sel] <= regs_q[data_ptr_sel]
                                    + `MCC_ADDR_ONE;
                            end else if (op_now == `MCC_OP_QOFF) begin
                                q_out <= 1'b0;
                            end else if (op_now == `MCC_OP_QON) begin
                                q_out <= 1'b1;
                            end else if (opcode_hi == `MCC_I_SEX) begin
                                data_ptr_sel <= opcode_lo;
                            end else if (opcode_hi == `MCC_I_SEP) begin
                                pc_sel <= opcode_lo;
                            end
                        end
                        if (cyc_end) begin
                            if (opcode_hi == `MCC_I_LONG) begin
                                st_q <= ST_EXEC2;
                            end else begin
                                started_q <= 1'b1;
                                st_q <= st_next;
                                dma_dir_in_q <= dir_next;
                            end
                        end
                    end
                    ST_EXEC2: begin
                        if (cyc_end) begin
                            started_q <= 1'b1;
                            st_q <= st_next;
                            dma_dir_in_q <= dir_next;
                        end
                    end
                    ST_DMA: begin
                        if (tpb_now) begin
                            regs_q[0] <= regs_q[0] + `MCC_ADDR_ONE;
                        end
                        if (cyc_end) begin
                            started_q <= 1'b1;
                            st_q <= st_next;
                            dma_dir_in_q <= dir_next;
                        end
                    end
                    ST_INT: begin
                        if (cyc_end) begin
                            interrupt_enable_flag <= 1'b0;
                            data_ptr_sel <= `MCC_INT_X;
                            pc_sel <= `MCC_INT_P;
                            st_q <= st_next;
                            dma_dir_in_q <= dir_next;
                        end
                    end
                    default: begin
                        st_q <= ST_INIT;
                    end
                endcase
            end
        end
    end

endmodule

// >>> test/mcc_mem_model.sv
`timescale 1ns/1ps
module mcc_mem_model (
    input wire sys_clk,
    input wire [15:0] mem_addr,
    input wire mem_read_strobe_n,
    input wire mem_write_strobe_n,
    input wire data_bus_oe,
    input wire [7:0] data_bus_out,
    input wire dev_drive,
    input wire [7:0] dev_byte,
    output wire [7:0] data_bus_in
);
    logic [7:0] mem [0:255];
    // Pull-ups hold an undriven bus high
    assign data_bus_in = data_bus_oe ? data_bus_out :
        !mem_read_strobe_n ? mem[mem_addr[7:0]] :
        dev_drive ? dev_byte : 8'hff;
    always @(posedge sys_clk) begin
        if (!mem_write_strobe_n) begin
            mem[mem_addr[7:0]] <= data_bus_in;
        end
    end
endmodule

// >>> test/mcc_core_props.sv
`timescale 1ns/1ps
module mcc_core_props (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire clear_n,
    input wire wait_n,
    input wire dma_out_req,
    input wire [15:0] mem_addr,
    input wire mem_read_strobe_n,
    input wire mem_write_strobe_n,
    input wire timing_pulse_first,
    input wire timing_pulse_second,
    input wire [1:0] state_code,
    input wire [3:0] pc_sel,
    input wire interrupt_enable_flag
);
    wire live = clk_en && !(clear_n ^ wait_n);
    wire rst_mode = clk_en && !clear_n && wait_n;
    reg [7:0] ok_q, rd_q, ps_q, cl_q, ld_q;
    function automatic [7:0] bump(input [7:0] v, input c);
        bump = !c ? 8'h00 : (v == 8'hff) ? v : v + 8'h01;
    endfunction
    // Run lengths of control levels and of the read strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ok_q <= 8'h00;
            rd_q <= 8'h00;
            ps_q <= 8'h00;
            cl_q <= 8'h00;
            ld_q <= 8'h00;
        end else begin
            ok_q <= bump(ok_q, live);
            rd_q <= bump(rd_q, !mem_read_strobe_n);
            ps_q <= bump(ps_q, clk_en && clear_n && !wait_n);
            cl_q <= bump(cl_q, clear_n);
            ld_q <= bump(ld_q, live && !clear_n && !dma_out_req);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_reset_quiet: assert property (
        rst_mode[*6] |-> !timing_pulse_first && !timing_pulse_second)
        else $error("timing pulse in reset mode");
    chk_reset_state: assert property (
        rst_mode[*6] |-> pc_sel == 4'h0 && interrupt_enable_flag)
        else $error("reset mode state wrong");
    chk_pulse_gap: assert property (
        $rose(timing_pulse_first) && ok_q >= 8'h06 && live ##1 live[*4]
        |=> timing_pulse_second)
        else $error("second pulse misplaced");
    chk_cycle_len: assert property (
        $rose(timing_pulse_first) && ok_q >= 8'h06 && live ##1 live[*7]
        |=> $rose(timing_pulse_first))
        else $error("machine cycle not eight clocks");
    chk_read_len: assert property (
        $rose(mem_read_strobe_n) && ok_q >= 8'h04 |-> rd_q >= 8'h08)
        else $error("read strobe too short");
    chk_write_pulse: assert property (
        $fell(mem_write_strobe_n) && ok_q >= 8'h04 && live ##1 live
        |-> !mem_write_strobe_n && $stable(mem_addr) ##1 mem_write_strobe_n)
        else $error("write pulse wrong");
    chk_pause_hold: assert property (
        ps_q >= 8'h05 && cl_q >= 8'h14 |=> $stable(mem_addr) && $stable(state_code)
        && $stable(timing_pulse_first) && $stable(mem_read_strobe_n))
        else $error("outputs moved while paused");
    chk_load_idle: assert property (
        ld_q >= 8'h14 |-> mem_read_strobe_n && state_code != 2'h3)
        else $error("activity in load idle");
endmodule
bind mcc_core mcc_core_props i_props (.*);

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "mcc_defs.vh"
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic clear_n = 1'b0;
    logic wait_n = 1'b1;
    logic dma_in_req = 1'b0;
    logic dma_out_req = 1'b0;
    logic int_req = 1'b0;
    logic dev_drive = 1'b0;
    logic rd_d = 1'b1;
    logic wr_d = 1'b1;
    logic saw_int = 1'b0;
    logic [15:0] a_d = 16'h0000;
    logic [15:0] snap;
    wire [7:0] data_bus_in, data_bus_out, dev_byte;
    wire [15:0] mem_addr;
    wire [1:0] state_code;
    wire [3:0] opcode_hi, opcode_lo, data_ptr_sel, pc_sel;
    wire data_bus_oe, mem_read_strobe_n, mem_write_strobe_n, q_out;
    wire interrupt_enable_flag, timing_pulse_first, timing_pulse_second;
    logic [7:0] prog [0:7] = '{8'h71, 8'h00, 8'h7b, 8'he5, 8'h7a, 8'he5, 8'he5, 8'he5};
    logic [1:0] sc_q [$];
    integer fails = 0, total_checks = 0, cycles = 0, exp_rd = 0, nw = 0, t0;
    integer seed = 32'h2300;
    assign dev_byte = prog[nw[2:0]];
    mcc_core i_dut (.*);
    mcc_mem_model i_mem (.*);
    always #5 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic start_run();
        clear_n = 1'b0;
        wait_n = 1'b1;
        cyc(10);
        check("reset_ie", interrupt_enable_flag, `MCC_IE_RST);
        exp_rd = 0;
        sc_q.delete();
        clear_n = 1'b1;
        t0 = cycles;
        for (int k = 0; k < 100 && sc_q.size() == 0; k++) cyc(1);
        check("start_delay", (cycles - t0 >= 9) && (cycles - t0 <= 14), 1'b1);
    endtask

    // Fetch, operand and DMA-out reads all walk upward from 0000
    always @(negedge sys_clk) begin
        if (state_code === `MCC_SC_INT) saw_int = 1'b1;
        if (!mem_read_strobe_n && (rd_d || mem_addr !== a_d)) begin
            sc_q.push_back(state_code);
            check("read_addr", mem_addr, exp_rd[15:0]);
            exp_rd = exp_rd + 1;
        end
        if (wr_d && !mem_write_strobe_n) check("write_addr", mem_addr, nw[15:0]);
        if (!wr_d && mem_write_strobe_n) nw = nw + 1;
        rd_d = mem_read_strobe_n;
        wr_d = mem_write_strobe_n;
        a_d = mem_addr;
    end

    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    initial begin
        for (int k = 0; k < 256; k++) i_mem.mem[k] = 8'he5;
        cyc(8);
        rst_n = 1'b1;
        cyc(12);
        check("reset_bus", data_bus_out, 8'h00);
        check("reset_p", pc_sel, 4'h0);
        wait_n = 1'b0;
        cyc(24);
        dev_drive = 1'b1;
        dma_in_req = 1'b1;
        for (int k = 0; k < 400 && nw < 5; k++) cyc(1);
        dma_in_req = 1'b0;
        cyc(30);
        dev_drive = 1'b0;
        for (int k = 0; k < 5; k++) check("loaded", i_mem.mem[k], prog[k]);
        wait_n = 1'b1;
        cyc(3);
        int_req = 1'b1;
        start_run();
        check("first_fetch", sc_q[0], `MCC_SC_FETCH);
        cyc(120);
        check("ie_cleared", interrupt_enable_flag, 1'b0);
        check("x_final", data_ptr_sel, 4'h5);
        check("q_final", q_out, 1'b0);
        check("last_op", {opcode_hi, opcode_lo}, 8'he5);
        check("no_int", saw_int, 1'b0);
        cyc($unsigned($random(seed)) % 8);
        wait_n = 1'b0;
        dma_out_req = 1'b1;
        cyc(4);
        snap = {14'h0000, state_code};
        cyc(16 + $unsigned($random(seed)) % 16);
        check("pause_state", {14'h0000, state_code}, snap);
        wait_n = 1'b1;
        for (int k = 0; k < 40 && state_code !== `MCC_SC_DMA; k++) cyc(1);
        check("resume_dma", state_code, `MCC_SC_DMA);
        dma_out_req = 1'b0;
        cyc(5);
        clk_en = 1'b0;
        snap = mem_addr;
        cyc(30);
        check("stop_addr", mem_addr, snap);
        clk_en = 1'b1;
        cyc(40);
        int_req = 1'b0;
        dma_out_req = 1'b1;
        start_run();
        check("dma_first", sc_q[0], `MCC_SC_DMA);
        dma_out_req = 1'b0;
        cyc(40);
        end_of_test();
    end
endmodule
